// ---- hdl/lpbt_pkg.sv ----
/*
 * Constants, types and lookup functions for the LED pulse and breathe timing block.
 * Assumes a single 50 MHz clock and an 8-bit register port driven by local logic.
 */
`default_nettype none

package lpbt_pkg;

   // Register offsets.
   localparam logic [7:0] ADDR_PULSE_A_PERIOD = 8'h84;
   localparam logic [7:0] ADDR_PULSE_B_PERIOD = 8'h85;
   localparam logic [7:0] ADDR_BREATH_PERIOD = 8'h86;
   localparam logic [7:0] ADDR_PULSE_COUNT_CONFIG = 8'h88;
   localparam logic [7:0] ADDR_STATUS = 8'h8f;
   localparam logic [7:0] ADDR_PULSE_A_DUTY = 8'h90;
   localparam logic [7:0] ADDR_PULSE_B_DUTY = 8'h91;
   localparam logic [7:0] ADDR_BREATH_DUTY = 8'h92;
   localparam logic [7:0] ADDR_STEADY_DUTY = 8'h93;

   // Reset values.
   localparam logic [7:0] RST_PULSE_A_PERIOD = 8'h20;
   localparam logic [7:0] RST_PULSE_B_PERIOD = 8'h14;
   localparam logic [7:0] RST_BREATH_PERIOD = 8'h5d;
   localparam logic [7:0] RST_PULSE_COUNT_CONFIG = 8'h24;
   localparam logic [7:0] RST_DUTY_LIMITS = 8'hf0;

   // Field positions.
   localparam int START_EDGE_BIT = 7;
   localparam int PERIOD_MSB = 6;
   localparam int NOTIFY_BIT = 6;
   localparam int CNT_B_LSB = 3;
   localparam int CNT_A_LSB = 0;
   localparam int CNT_W = 3;
   localparam int LIM_HI_LSB = 4;
   localparam int LIM_LO_LSB = 0;
   localparam int LIM_W = 4;
   localparam int BUSY_BIT = 7;

   // Behavior select codes.
   localparam logic [1:0] SEL_DIRECT = 2'h0;
   localparam logic [1:0] SEL_PULSE_A = 2'h1;
   localparam logic [1:0] SEL_PULSE_B = 2'h2;
   localparam logic [1:0] SEL_BREATH = 2'h3;

   // Timing: one period unit, ramp steps per period and PWM resolution.
   localparam int UNIT_MS = 32;
   localparam int CLK_HZ = 50_000_000;
   localparam int UNIT_CYC = int'(64'(UNIT_MS) * 64'(CLK_HZ) / 64'd1000);
   localparam int RAMP_STEPS = 64;
   localparam int RAMP_HALF = RAMP_STEPS / 2;
   localparam int STEP_CYC_DEF = UNIT_CYC / RAMP_STEPS;
   localparam int PWM_STEPS = 100;

   typedef enum logic [2:0] {
      ST_IDLE = 3'b001,
      ST_RAMP = 3'b010,
      ST_COUNT = 3'b100
   } lpbt_state_e;

   // Upper duty limit code to percent.
   function automatic logic [6:0] lpbt_high_pct(input logic [3:0] code);
      case (code)
         4'h0: return 7'h07;
         4'h1: return 7'h09;
         4'h2: return 7'h0b;
         4'h3: return 7'h0e;
         4'h4: return 7'h11;
         4'h5: return 7'h14;
         4'h6: return 7'h17;
         4'h7: return 7'h1a;
         4'h8: return 7'h1e;
         4'h9: return 7'h23;
         4'ha: return 7'h28;
         4'hb: return 7'h2e;
         4'hc: return 7'h35;
         4'hd: return 7'h3f;
         4'he: return 7'h4d;
         default: return 7'h64;
      endcase
   endfunction

   // Lower duty limit code to percent: one code below the upper table.
   function automatic logic [6:0] lpbt_low_pct(input logic [3:0] code);
      return (code == 4'h0) ? 7'h00 : lpbt_high_pct(code - 4'h1);
   endfunction

   // Period field to units; a zero field behaves as one.
   function automatic logic [6:0] lpbt_units(input logic [6:0] field);
      return (field == 7'h00) ? 7'h01 : field;
   endfunction

endpackage

`default_nettype wire

// ---- hdl/lpbt_regs.sv ----
/*
 * Register store of the LED timing block with registered read data.
 * Assumes one-cycle strobes that never coincide; read data appear in the next cycle only.
 */
`default_nettype none

module lpbt_regs
   import lpbt_pkg::*;
(
   // Clock and reset.
   input wire logic clock_i,
   input wire logic rstn_i,
   // Register port.
   input wire logic [7:0] addr_i,
   input wire logic [7:0] wdata_i,
   input wire logic wr_i,
   input wire logic rd_i,
   output logic [7:0] rdata_o,
   // Block side.
   input wire logic sleep_i,
   input wire logic [7:0] status_i,
   output logic [7:0] pulse_a_period_o,
   output logic [7:0] pulse_b_period_o,
   output logic [7:0] breath_period_o,
   output logic [7:0] pulse_count_config_o,
   output logic [7:0] pulse_a_duty_limits_o,
   output logic [7:0] pulse_b_duty_limits_o,
   output logic [7:0] breath_duty_limits_o,
   output logic [7:0] steady_duty_limits_o
);

   typedef struct packed {
      logic [7:0] pa;
      logic [7:0] pb;
      logic [7:0] br;
      logic [7:0] cfg;
      logic [7:0] da;
      logic [7:0] db;
      logic [7:0] dbr;
      logic [7:0] dst;
      logic [7:0] rdata;
   } lpbt_regs_s;

   lpbt_regs_s r_reg;
   lpbt_regs_s r_next;

   // Writes, sleep clearing and the read mux.
   always_comb begin
      r_next = r_reg;
      r_next.rdata = 8'h00;
      if (wr_i) begin
         case (addr_i)
            ADDR_PULSE_A_PERIOD: r_next.pa = wdata_i;
            ADDR_PULSE_B_PERIOD: r_next.pb = {1'b0, wdata_i[PERIOD_MSB:0]};
            ADDR_BREATH_PERIOD: r_next.br = {1'b0, wdata_i[PERIOD_MSB:0]};
            ADDR_PULSE_COUNT_CONFIG: r_next.cfg = {1'b0, wdata_i[NOTIFY_BIT:0]};
            ADDR_PULSE_A_DUTY: r_next.da = wdata_i;
            ADDR_PULSE_B_DUTY: r_next.db = wdata_i;
            ADDR_BREATH_DUTY: r_next.dbr = wdata_i;
            ADDR_STEADY_DUTY: r_next.dst = wdata_i;
            default: r_next.rdata = r_next.rdata;
         endcase
      end
      if (sleep_i) begin
         r_next.cfg[NOTIFY_BIT] = 1'b0;
      end
      if (rd_i) begin
         case (addr_i)
            ADDR_PULSE_A_PERIOD: r_next.rdata = r_reg.pa;
            ADDR_PULSE_B_PERIOD: r_next.rdata = r_reg.pb;
            ADDR_BREATH_PERIOD: r_next.rdata = r_reg.br;
            ADDR_PULSE_COUNT_CONFIG: r_next.rdata = r_reg.cfg;
            ADDR_STATUS: r_next.rdata = status_i;
            ADDR_PULSE_A_DUTY: r_next.rdata = r_reg.da;
            ADDR_PULSE_B_DUTY: r_next.rdata = r_reg.db;
            ADDR_BREATH_DUTY: r_next.rdata = r_reg.dbr;
            ADDR_STEADY_DUTY: r_next.rdata = r_reg.dst;
            default: r_next.rdata = 8'h00;
         endcase
      end
   end

   // State register with reset defaults.
   always_ff @(posedge clock_i) begin
      if (!rstn_i) begin
         r_reg <= '{pa: RST_PULSE_A_PERIOD, pb: RST_PULSE_B_PERIOD, br: RST_BREATH_PERIOD,
                    cfg: RST_PULSE_COUNT_CONFIG, da: RST_DUTY_LIMITS, db: RST_DUTY_LIMITS,
                    dbr: RST_DUTY_LIMITS, dst: RST_DUTY_LIMITS, rdata: 8'h00};
      end else begin
         r_reg <= r_next;
      end
   end

   // Outputs come straight from the store.
   assign rdata_o = r_reg.rdata;
   assign pulse_a_period_o = r_reg.pa;
   assign pulse_b_period_o = r_reg.pb;
   assign breath_period_o = r_reg.br;
   assign pulse_count_config_o = r_reg.cfg;
   assign pulse_a_duty_limits_o = r_reg.da;
   assign pulse_b_duty_limits_o = r_reg.db;
   assign breath_duty_limits_o = r_reg.dbr;
   assign steady_duty_limits_o = r_reg.dst;

endmodule

`default_nettype wire

// ---- hdl/lpbt_top.sv ----
/*
 * LED pulse, breathe and direct brightness timing for one LED output with its registers.
 * Assumes touch, drive bit, behavior select and sleep flag come from logic on clock_i.
 */
// What this block does
// - Period field counts 32 ms; zero acts as one
// - Period spans 32 ms to about 4.06 s
// - Pulse A period register with start edge
// - Start edge zero: start on actuation
// - Start edge one: start on release
// - Pulse B period register, top bit unused
// - Breath period register, top bit unused
// - Config register holds counts and notify enable
// - Bits 5..3 give pulse B count
// - Bits 2..0 give pulse A count
// - Enabled: notify when drive-actuated behavior finishes
// - Disabled: never notify on finish
// - Deepest sleep flag clears notify enable
// - Four duty limit registers, high and low
// - Ramp duty from low to high and back
// - High code maps to nonlinear percent table
// - Low code maps one code below high
// - Direct mode applies limits at once
// - Other modes latch limits when the behavior starts
// - Two-bit select picks behavior and registers
// - Breath rise and fall each half period
// - Pulse B tail pulses then settles low
`default_nettype none

module lpbt_top
   import lpbt_pkg::*;
#(
   parameter int unsigned STEP_CYC = STEP_CYC_DEF
)
(
   // Clock and reset.
   input wire logic clock_i,
   input wire logic rstn_i,
   // Register port.
   input wire logic [7:0] reg_addr_i,
   input wire logic [7:0] reg_wdata_i,
   input wire logic reg_wr_i,
   input wire logic reg_rd_i,
   output logic [7:0] reg_rdata_o,
   // LED control inputs.
   input wire logic [1:0] behavior_sel_i,
   input wire logic touch_i,
   input wire logic drive_bit_i,
   input wire logic deepest_sleep_flag_i,
   // LED and host notification outputs.
   output logic led_pwm_o,
   output logic alert_o
);

   typedef struct packed {
      lpbt_state_e state;
      logic [23:0] sub_cnt;
      logic [6:0] unit_cnt;
      logic [6:0] units;
      logic [5:0] step;
      logic [2:0] pulses_left;
      logic [3:0] lim_hi;
      logic [3:0] lim_lo;
      logic tch_q;
      logic drv_q;
      logic drive_src;
      logic [6:0] pwm_cnt;
      logic pwm;
      logic alert;
      logic [6:0] duty;
   } lpbt_core_s;

   lpbt_core_s core;
   lpbt_core_s nxt;

   logic [7:0] pa_reg_val;
   logic [7:0] pb_reg_val;
   logic [7:0] br_reg_val;
   logic [7:0] cfg_reg_val;
   logic [7:0] duty_a_val;
   logic [7:0] duty_b_val;
   logic [7:0] duty_br_val;
   logic [7:0] duty_st_val;
   logic [7:0] status_val;
   logic pulse_start_edge_sel;
   logic [6:0] pulse_a_period_field;
   logic [6:0] pulse_b_period_field;
   logic [6:0] breath_period_field;
   logic [2:0] pulse_a_count;
   logic [2:0] pulse_b_count;
   logic notify_en;
   logic [3:0] steady_duty_high;
   logic [3:0] steady_duty_low;
   logic act;
   logic act_q;
   logic rise;
   logic fall;
   logic drv_edge;
   logic start_a;
   logic last_sub;
   logic last_unit;
   logic period_end;
   logic [6:0] sel_units;
   logic [3:0] sel_hi;
   logic [3:0] sel_lo;
   logic load;
   logic restart;
   logic done;
   logic [6:0] cur_lo_pct;
   logic [6:0] dir_pct;

   // Ramped duty: rises over the first half of the steps and falls over the second.
   function automatic logic [6:0] lpbt_ramp(input logic [6:0] lo, input logic [6:0] hi,
                                            input logic [5:0] step);
      logic [6:0] pos;
      logic [6:0] diff;
      logic [13:0] prod;
      pos = (step <= 6'(RAMP_HALF)) ? {1'b0, step} : 7'(RAMP_STEPS) - {1'b0, step};
      diff = (hi > lo) ? hi - lo : 7'h00;
      prod = diff * pos;
      return lo + prod[11:5];
   endfunction

   lpbt_regs u_regs (
      .clock_i(clock_i),
      .rstn_i(rstn_i),
      .addr_i(reg_addr_i),
      .wdata_i(reg_wdata_i),
      .wr_i(reg_wr_i),
      .rd_i(reg_rd_i),
      .rdata_o(reg_rdata_o),
      .sleep_i(deepest_sleep_flag_i),
      .status_i(status_val),
      .pulse_a_period_o(pa_reg_val),
      .pulse_b_period_o(pb_reg_val),
      .breath_period_o(br_reg_val),
      .pulse_count_config_o(cfg_reg_val),
      .pulse_a_duty_limits_o(duty_a_val),
      .pulse_b_duty_limits_o(duty_b_val),
      .breath_duty_limits_o(duty_br_val),
      .steady_duty_limits_o(duty_st_val)
   );

   assign pulse_start_edge_sel = pa_reg_val[START_EDGE_BIT];
   assign pulse_a_period_field = pa_reg_val[PERIOD_MSB:0];
   assign pulse_b_period_field = pb_reg_val[PERIOD_MSB:0];
   assign breath_period_field = br_reg_val[PERIOD_MSB:0];
   assign pulse_b_count = cfg_reg_val[CNT_B_LSB +: CNT_W];
   assign pulse_a_count = cfg_reg_val[CNT_A_LSB +: CNT_W];
   assign notify_en = cfg_reg_val[NOTIFY_BIT];
   assign steady_duty_high = duty_st_val[LIM_HI_LSB +: LIM_W];
   assign steady_duty_low = duty_st_val[LIM_LO_LSB +: LIM_W];
   // Status shows activity and the present duty.
   assign status_val = {core.state != ST_IDLE, core.duty};

   // Actuation edges; a drive bit change marks a register-actuated start.
   assign act = touch_i | drive_bit_i;
   assign act_q = core.tch_q | core.drv_q;
   assign rise = act & ~act_q;
   assign fall = ~act & act_q;
   assign drv_edge = drive_bit_i != core.drv_q;
   assign start_a = pulse_start_edge_sel ? fall : rise;

   assign last_sub = core.sub_cnt == 24'(STEP_CYC - 1);
   assign last_unit = core.unit_cnt == core.units - 7'h01;
   assign period_end = last_sub && last_unit && (core.step == 6'(RAMP_STEPS - 1));

   always_comb begin
      case (behavior_sel_i)
         SEL_PULSE_A: begin
            sel_units = lpbt_units(pulse_a_period_field);
            sel_hi = duty_a_val[LIM_HI_LSB +: LIM_W];
            sel_lo = duty_a_val[LIM_LO_LSB +: LIM_W];
         end
         SEL_PULSE_B: begin
            sel_units = lpbt_units(pulse_b_period_field);
            sel_hi = duty_b_val[LIM_HI_LSB +: LIM_W];
            sel_lo = duty_b_val[LIM_LO_LSB +: LIM_W];
         end
         SEL_BREATH: begin
            sel_units = lpbt_units(breath_period_field);
            sel_hi = duty_br_val[LIM_HI_LSB +: LIM_W];
            sel_lo = duty_br_val[LIM_LO_LSB +: LIM_W];
         end
         default: begin
            sel_units = 7'h01;
            sel_hi = steady_duty_high;
            sel_lo = steady_duty_low;
         end
      endcase
   end

   // Next state: timebase, behavior sequencing, duty and PWM.
   always_comb begin
      nxt = core;
      load = 1'b0;
      restart = 1'b0;
      done = 1'b0;
      nxt.tch_q = touch_i;
      nxt.drv_q = drive_bit_i;
      if (core.state != ST_IDLE) begin
         if (last_sub) begin
            nxt.sub_cnt = 24'h000000;
            if (last_unit) begin
               nxt.unit_cnt = 7'h00;
               nxt.step = core.step + 6'h01;
            end else begin
               nxt.unit_cnt = core.unit_cnt + 7'h01;
            end
         end else begin
            nxt.sub_cnt = core.sub_cnt + 24'h000001;
         end
      end
      case (core.state)
         ST_IDLE: begin
            if (behavior_sel_i == SEL_PULSE_A && start_a) begin
               load = 1'b1;
               nxt.state = ST_COUNT;
               nxt.pulses_left = pulse_a_count;
            end else if ((behavior_sel_i inside {SEL_PULSE_B, SEL_BREATH}) && rise) begin
               load = 1'b1;
               nxt.state = ST_RAMP;
            end
         end
         ST_RAMP: begin
            if (behavior_sel_i == SEL_PULSE_B) begin
               if (fall) begin
                  restart = 1'b1;
                  nxt.state = ST_COUNT;
                  nxt.pulses_left = pulse_b_count;
               end
            end else if (behavior_sel_i == SEL_BREATH) begin
               if (!act) begin
                  nxt.state = ST_IDLE;
                  done = 1'b1;
               end
            end else begin
               nxt.state = ST_IDLE;
            end
         end
         ST_COUNT: begin
            if (behavior_sel_i == SEL_DIRECT) begin
               nxt.state = ST_IDLE;
            end else if (period_end) begin
               if (core.pulses_left == 3'h0) begin
                  nxt.state = ST_IDLE;
                  done = 1'b1;
               end else begin
                  nxt.pulses_left = core.pulses_left - 3'h1;
               end
            end
         end
         default: begin
            nxt.state = ST_IDLE;
         end
      endcase
      if (load) begin
         nxt.units = sel_units;
         nxt.lim_hi = sel_hi;
         nxt.lim_lo = sel_lo;
         nxt.drive_src = drv_edge;
      end
      if (load || restart || nxt.state == ST_IDLE) begin
         nxt.sub_cnt = 24'h000000;
         nxt.unit_cnt = 7'h00;
         nxt.step = 6'h00;
      end
      nxt.alert = done & core.drive_src & notify_en;
      if (behavior_sel_i == SEL_DIRECT) begin
         nxt.duty = dir_pct;
      end else if (core.state == ST_IDLE) begin
         nxt.duty = lpbt_low_pct(core.lim_lo);
      end else begin
         nxt.duty = lpbt_ramp(lpbt_low_pct(core.lim_lo), lpbt_high_pct(core.lim_hi), core.step);
      end
      nxt.pwm_cnt = (core.pwm_cnt == 7'(PWM_STEPS - 1)) ? 7'h00 : core.pwm_cnt + 7'h01;
      nxt.pwm = core.pwm_cnt < core.duty;
   end

   assign dir_pct = act ? lpbt_high_pct(steady_duty_high) : lpbt_low_pct(steady_duty_low);
   assign cur_lo_pct = lpbt_low_pct(core.lim_lo);

   // State register.
   always_ff @(posedge clock_i) begin
      if (!rstn_i) begin
         core <= '{state: ST_IDLE, units: 7'h01, lim_hi: RST_DUTY_LIMITS[7:4],
                   lim_lo: RST_DUTY_LIMITS[3:0], default: '0};
      end else begin
         core <= nxt;
      end
   end

   // Outputs straight from the state register.
   assign led_pwm_o = core.pwm;
   assign alert_o = core.alert;

   // Checks on the sequencing and outputs.
   default clocking cb @(posedge clock_i);
   endclocking
   default disable iff (!rstn_i);

   property p_pwm_zero;
      core.duty == 7'h00 [*2] |-> !led_pwm_o [*2];
   endproperty
   a_pwm_zero: assert property (p_pwm_zero) else $error("PWM high at zero duty");

   property p_pwm_full;
      (core.duty == 7'h64 && $stable(core.duty)) |=> led_pwm_o;
   endproperty
   a_pwm_full: assert property (p_pwm_full) else $error("PWM low at full duty");

   property p_alert_gated;
      alert_o |-> $past(notify_en) && $past(core.drive_src);
   endproperty
   a_alert_gated: assert property (p_alert_gated) else $error("Alert without enable");

   property p_sleep_clear;
      deepest_sleep_flag_i |=> !notify_en;
   endproperty
   a_sleep_clear: assert property (p_sleep_clear) else $error("Enable survived sleep");

   property p_direct_now;
      behavior_sel_i == SEL_DIRECT |=> core.duty == $past(dir_pct);
   endproperty
   a_direct_now: assert property (p_direct_now) else $error("Direct duty late");

   property p_pulse_a_start;
      (core.state == ST_IDLE && behavior_sel_i == SEL_PULSE_A && start_a)
         |=> core.state == ST_COUNT && core.pulses_left == $past(pulse_a_count) ##1
             core.state == ST_COUNT;
   endproperty
   a_pulse_a_start: assert property (p_pulse_a_start) else $error("Pulse A did not start");

   property p_release_start;
      (core.state == ST_IDLE && behavior_sel_i == SEL_PULSE_A && pulse_start_edge_sel && rise)
         |=> core.state == ST_IDLE;
   endproperty
   a_release_start: assert property (p_release_start) else $error("Pulse A on wrong edge");

   property p_tail;
      (core.state == ST_RAMP && behavior_sel_i == SEL_PULSE_B && fall) |=>
         core.state == ST_COUNT && core.step == 6'h00 && core.pulses_left == $past(pulse_b_count);
   endproperty
   a_tail: assert property (p_tail) else $error("Pulse B tail not entered");

   property p_ramp_floor;
      (core.state != ST_IDLE && behavior_sel_i != SEL_DIRECT) |=> core.duty >= $past(cur_lo_pct);
   endproperty
   a_ramp_floor: assert property (p_ramp_floor) else $error("Duty under low limit");

   property p_latched;
      (core.state == ST_RAMP && nxt.state == ST_RAMP) |=> $stable({core.lim_hi, core.units});
   endproperty
   a_latched: assert property (p_latched) else $error("Limits changed mid ramp");

   property p_units;
      core.units != 7'h00 && core.unit_cnt < core.units;
   endproperty
   a_units: assert property (p_units) else $error("Unit count out of range");

   c_pulse_a_done: cover property (core.state == ST_COUNT && behavior_sel_i == SEL_PULSE_A ##1
                                   core.state == ST_IDLE);
   c_alert: cover property (alert_o);
   c_tail: cover property (core.state == ST_RAMP ##1 core.state == ST_COUNT);
   c_breath_peak: cover property (behavior_sel_i == SEL_BREATH && core.step == 6'h20);

endmodule

`default_nettype wire

// ---- tb/lpbt_led_load.sv ----
/*
 * LED load model: counts the lit cycles of the LED drive in each frame.
 * Assumes a PWM frame of 100 clock cycles on the block's clock.
 */
`default_nettype none

module lpbt_led_load (
   // Clock and LED drive.
   input wire logic clock_i,
   input wire logic led_i,
   // Lit cycles in the last full frame.
   output logic [6:0] on_cnt_o
);
   timeunit 1ns;
   timeprecision 1ns;
   logic [6:0] cyc_reg = 7'h00;
   logic [6:0] acc_reg = 7'h00;

   // PWM on-time
   // Any 100 consecutive cycles of a steady duty hold exactly that many lit cycles.
   always_ff @(posedge clock_i) begin
      cyc_reg <= (cyc_reg == 7'h63) ? 7'h00 : cyc_reg + 7'h01;
      acc_reg <= (cyc_reg == 7'h63) ? 7'h00 : acc_reg + {6'h00, led_i};
      if (cyc_reg == 7'h63) begin
         on_cnt_o <= acc_reg + {6'h00, led_i};
      end
   end
endmodule

`default_nettype wire

// ---- tb/tb_led_pulse_breathe_timing.sv ----
/*
 * Bench of the LED timing block: register tasks, direct duty table and timed runs.
 * Assumes lpbt_top with a ramp step of 2 cycles and the LED load model beside it.
 */
`default_nettype none

module tb_led_pulse_breathe_timing
   import lpbt_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ns;
   localparam int PER_CYC = 128;
   logic clock_i = 1'b0;
   logic rstn_i = 1'b0;
   logic [7:0] addr = 8'h00;
   logic [7:0] wdata = 8'h00;
   logic wr = 1'b0;
   logic rd = 1'b0;
   logic [1:0] sel = SEL_DIRECT;
   logic touch = 1'b0;
   logic drive = 1'b0;
   logic sleep = 1'b0;
   logic [7:0] rdata;
   logic led;
   logic alert;
   logic [6:0] on_cnt;
   logic [6:0] exp7;
   logic [7:0] got;
   int errors = 0;
   int checks = 0;
   int k;
   logic [7:0] adr_tab [8] = '{8'h84, 8'h85, 8'h86, 8'h88, 8'h90, 8'h91, 8'h92, 8'h93};
   logic [7:0] rst_tab [8] = '{8'h20, 8'h14, 8'h5d, 8'h24, 8'hf0, 8'hf0, 8'hf0, 8'hf0};
   logic [7:0] msk_tab [8] = '{8'hff, 8'h7f, 8'h7f, 8'h7f, 8'hff, 8'hff, 8'hff, 8'hff};
   logic [6:0] pct_tab [16] = '{7'h07, 7'h09, 7'h0b, 7'h0e, 7'h11, 7'h14, 7'h17, 7'h1a,
      7'h1e, 7'h23, 7'h28, 7'h2e, 7'h35, 7'h3f, 7'h4d, 7'h64};

   // Clock of 20 ns.
   always #10 clock_i = ~clock_i;

   lpbt_top #(.STEP_CYC(2)) uut (.clock_i(clock_i), .rstn_i(rstn_i), .reg_addr_i(addr),
      .reg_wdata_i(wdata), .reg_wr_i(wr), .reg_rd_i(rd), .reg_rdata_o(rdata),
      .behavior_sel_i(sel), .touch_i(touch), .drive_bit_i(drive),
      .deepest_sleep_flag_i(sleep), .led_pwm_o(led), .alert_o(alert));

   lpbt_led_load load (.clock_i(clock_i), .led_i(led), .on_cnt_o(on_cnt));

   task automatic wrap_up();
      if (errors == 0 && checks > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask

   task automatic check(input logic [7:0] g, input logic [7:0] e);
      checks++;
      if (g !== e) begin
         errors++;
         $display("Error at %0t: got %h expected %h", $time, g, e);
      end
   endtask

   task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
      @(posedge clock_i);
      addr <= a;
      wdata <= d;
      wr <= 1'b1;
      @(posedge clock_i);
      wr <= 1'b0;
   endtask

   task automatic rd_reg(input logic [7:0] a);
      @(posedge clock_i);
      addr <= a;
      rd <= 1'b1;
      @(posedge clock_i);
      rd <= 1'b0;
      #1 got = rdata;
      // Let the next input change fall right after a rising edge.
      @(posedge clock_i);
   endtask

   // Arms one behavior, triggers it and times the finish notification.
   task automatic run(input logic [1:0] s, input logic [7:0] a, input logic [7:0] per,
      input logic [7:0] cfg, input int n);
      sel <= SEL_DIRECT;
      wr_reg(a, per);
      wr_reg(ADDR_PULSE_COUNT_CONFIG, cfg);
      sel <= s;
      drive <= (s == SEL_PULSE_A) & per[7];
      repeat (2) @(posedge clock_i);
      drive <= ~drive;
      if (s != SEL_PULSE_A) begin
         repeat (50) @(posedge clock_i);
         drive <= 1'b0;
      end
      for (k = 0; k < 1200 && alert !== 1'b1; k++) begin
         @(posedge clock_i);
         #1;
      end
      check(8'(k >= n - 4 && k <= n + 8), {7'h00, cfg[6]});
      if (k == 1200 && cfg[6])
         wrap_up();
      @(posedge clock_i);
      drive <= 1'b0;
   endtask

   initial begin
      repeat (2) @(posedge clock_i);
      rstn_i <= 1'b1;
      // Reset values, then writable bits with the unused top bits.
      for (int i = 0; i < 8; i++) begin
         rd_reg(adr_tab[i]);
         check(got, rst_tab[i]);
         wr_reg(adr_tab[i], 8'hff);
         rd_reg(adr_tab[i]);
         check(got, msk_tab[i]);
      end
      wr_reg(8'h87, 8'h55);
      rd_reg(8'h87);
      check(got, 8'h00);
      wr_reg(ADDR_PULSE_COUNT_CONFIG, 8'h40);
      @(posedge clock_i);
      sleep <= 1'b1;
      rd_reg(ADDR_PULSE_COUNT_CONFIG);
      check(got, 8'h00);
      sleep <= 1'b0;
      // Direct duty for every code, high with touch held and low after release.
      for (int c = 0; c < 16; c++) begin
         wr_reg(ADDR_STEADY_DUTY, {c[3:0], c[3:0]});
         for (int t = 0; t < 2; t++) begin
            touch <= ~t[0];
            exp7 = t[0] ? ((c == 0) ? 7'h00 : pct_tab[c - 1]) : pct_tab[c];
            repeat (202) @(posedge clock_i);
            check({1'b0, on_cnt}, {1'b0, exp7});
            rd_reg(ADDR_STATUS);
            check({1'b0, got[6:0]}, {1'b0, exp7});
         end
      end
      run(SEL_PULSE_A, ADDR_PULSE_A_PERIOD, 8'h01, 8'h40, PER_CYC);
      run(SEL_PULSE_A, ADDR_PULSE_A_PERIOD, 8'h80, 8'h42, 3 * PER_CYC);
      run(SEL_PULSE_A, ADDR_PULSE_A_PERIOD, 8'h02, 8'h40, 2 * PER_CYC);
      run(SEL_PULSE_A, ADDR_PULSE_A_PERIOD, 8'h01, 8'h00, PER_CYC);
      run(SEL_PULSE_B, ADDR_PULSE_B_PERIOD, 8'h01, 8'h48, 2 * PER_CYC);
      run(SEL_BREATH, ADDR_BREATH_PERIOD, 8'h01, 8'h40, 0);
      wrap_up();
   end
endmodule

`default_nettype wire
